// ---- hw/pleb_pkg.sv ----
// Package of register map, field layout and timing constants for the PWM blanking block.
package pleb_pkg;

  // ----------------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned DLY_W = 9;
  localparam int unsigned SEL_W = 4;
  localparam int unsigned NUM_SRC = 16;

  // ----------------------------------------------------------------------
  // Register map (byte addresses, one 32-bit word each, per channel)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CH_STRIDE = 8'h10;
  localparam logic [3:0] OFS_CONTROL = 4'h0;
  localparam logic [3:0] OFS_DELAY = 4'h4;
  localparam logic [3:0] OFS_AUX = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int unsigned CTL_LOW_BIT = 0;
  localparam int unsigned CTL_HIGH_BIT = 1;
  localparam int unsigned DLY_LSB = 3;
  localparam int unsigned DLY_MSB = 11;
  localparam int unsigned AUX_SEL_LSB = 0;
  localparam int unsigned AUX_SEL_MSB = 3;
  localparam int unsigned STAT_BLANK_BIT = 0;
  localparam int unsigned STAT_CNT_LSB = 4;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [DLY_W-1:0] DELAY_RESET = 9'h000;
  localparam logic [SEL_W-1:0] AUX_RESET = 4'h0;

  // ----------------------------------------------------------------------
  // Timing: one delay step in picoseconds, and the clock period
  // ----------------------------------------------------------------------
  localparam int unsigned STEP_PS = 8320;
  localparam int unsigned PCLK_PS = 40000;

  // ----------------------------------------------------------------------
  // Per-channel configuration carrier
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic blank_when_low_side_high;
    logic blank_when_low_side_low;
    logic [DLY_W-1:0] blanking_delay_count;
    logic [SEL_W-1:0] blanking_source_select;
  } pleb_cfg_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BLANK = 2'b10
  } pleb_state_e;

endpackage : pleb_pkg

// ---- hw/pleb_step_div.sv ----
// Divider that turns 8.32 ns delay steps into pclk-rate step enables.
`timescale 1ns/1ps
module pleb_step_div (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Restart the accumulator together with a new blanking interval
  input wire logic restart,
  // One pulse per clock carrying how many delay steps elapsed
  output logic [3:0] steps
);

  logic [15:0] acc_q, acc_d;
  logic [16:0] sum;

  // Accumulate clock time, emitting whole steps; 40 ns holds 4 or 5 steps.
  always_comb begin
    sum = {1'b0, (restart ? 16'h0000 : acc_q)} + 17'(pleb_pkg::PCLK_PS);
    steps = 4'(sum / 17'(pleb_pkg::STEP_PS));
    acc_d = 16'(sum - 17'(steps) * 17'(pleb_pkg::STEP_PS));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= 16'h0000;
    end else begin
      acc_q <= acc_d;
    end
  end

endmodule : pleb_step_div

// ---- hw/pleb_channel.sv ----
// One channel of leading-edge blanking: edge detect, countdown and suppression.
`timescale 1ns/1ps
module pleb_channel (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Configuration
  input wire pleb_pkg::pleb_cfg_s cfg,
  // Synchronised low-side output and selected blanking source
  input wire logic pwm_low_side_output,
  input wire logic blank_source,
  // Raw fault and current-limit inputs
  input wire logic fault_in,
  input wire logic climit_in,
  // Gated inputs and state
  output logic fault_out,
  output logic climit_out,
  output logic blanking,
  output logic [pleb_pkg::DLY_W-1:0] count
);

  pleb_pkg::pleb_state_e state_q, state_d;
  logic [pleb_pkg::DLY_W-1:0] cnt_q, cnt_d;
  logic src_q, src_d;
  logic fault_q, fault_d, climit_q, climit_d;
  logic [3:0] steps;
  logic edge_seen;
  logic state_blank;

  assign edge_seen = blank_source & ~src_q;

  pleb_step_div u_div (
    .pclk(pclk),
    .presetn(presetn),
    .restart(edge_seen),
    .steps(steps)
  );

  always_comb begin
    // R1 high-state blanking
    state_blank = cfg.blank_when_low_side_high & pwm_low_side_output;
    // R2 low-state blanking
    state_blank = state_blank | (cfg.blank_when_low_side_low & ~pwm_low_side_output);
    src_d = blank_source;
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      pleb_pkg::ST_IDLE: begin
        // R7 edge loads counter
        if (edge_seen && cfg.blanking_delay_count != '0) begin
          state_d = pleb_pkg::ST_BLANK;
          cnt_d = cfg.blanking_delay_count;
        end
      end
      pleb_pkg::ST_BLANK: begin
        if (edge_seen) begin
          cnt_d = cfg.blanking_delay_count;
        end else if ({5'h00, steps} >= cnt_q) begin
          cnt_d = '0;
          state_d = pleb_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q - 9'({5'h00, steps});
        end
      end
      default: begin
        state_d = pleb_pkg::ST_IDLE;
        cnt_d = '0;
      end
    endcase
    // R7 suppress until expiry
    fault_d = fault_in & ~state_blank & (state_q != pleb_pkg::ST_BLANK);
    climit_d = climit_in & ~state_blank & (state_q != pleb_pkg::ST_BLANK);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= pleb_pkg::ST_IDLE;
      cnt_q <= '0;
      src_q <= 1'b0;
      fault_q <= 1'b0;
      climit_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      src_q <= src_d;
      fault_q <= fault_d;
      climit_q <= climit_d;
    end
  end

  assign fault_out = fault_q;
  assign climit_out = climit_q;
  assign blanking = (state_q == pleb_pkg::ST_BLANK) | state_blank;
  assign count = cnt_q;

  // R1 output gated high
  AST_HIGH_BLANK: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.blank_when_low_side_high && pwm_low_side_output) |=> !fault_q && !climit_q)
    else $error("fault passed while low side high blanked"); // R1
  // R2 output gated low
  AST_LOW_BLANK: assert property (@(posedge pclk) disable iff (!presetn)
    (cfg.blank_when_low_side_low && !pwm_low_side_output) |=> !fault_q && !climit_q)
    else $error("fault passed while low side low blanked"); // R2
  // R2 no blanking when clear
  AST_NO_STATE_BLANK: assert property (@(posedge pclk) disable iff (!presetn)
    (!cfg.blank_when_low_side_low && !cfg.blank_when_low_side_high
     && state_q == pleb_pkg::ST_IDLE && fault_in) |=> fault_q)
    else $error("fault dropped without blanking"); // R2
  // R7 edge starts countdown
  AST_EDGE_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == pleb_pkg::ST_IDLE && edge_seen && cfg.blanking_delay_count != '0)
    |=> state_q == pleb_pkg::ST_BLANK && cnt_q == $past(cfg.blanking_delay_count))
    else $error("blanking counter not loaded on edge"); // R7
  // R7 countdown is bounded
  AST_EXPIRE: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == pleb_pkg::ST_BLANK && !edge_seen) |=> cnt_q < $past(cnt_q)
      || state_q == pleb_pkg::ST_IDLE || $past(edge_seen))
    else $error("blanking counter stalled"); // R7
  // R7 blanked during countdown
  AST_COUNT_SUPPRESS: assert property (@(posedge pclk) disable iff (!presetn)
    (state_q == pleb_pkg::ST_BLANK) |=> !fault_q && !climit_q)
    else $error("fault passed during blanking count"); // R7

endmodule : pleb_channel

// ---- hw/pleb_top.sv ----
// APB-mapped leading-edge blanking for eight PWM channels.
`timescale 1ns/1ps
// Function
// R1: Blank inputs while low side high enabled.
// R2: Blank inputs while low side low enabled.
// R3: Nine-bit delay in bits 11..3, 8.32 ns.
// R4: Four-bit source select picks blanking trigger.
// R5: Delay unused bits read zero, reset zero.
// R6: Eight independent channel register sets.
// R7: Qualifying edge loads counter; ignore until expiry.
module pleb_top (
  // APB clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // PWM side
  input wire logic [pleb_pkg::NUM_CH-1:0] pwm_low_side_output,
  input wire logic [pleb_pkg::NUM_SRC-1:0] blank_sources,
  // Fault and current-limit side
  input wire logic [pleb_pkg::NUM_CH-1:0] fault_in,
  input wire logic [pleb_pkg::NUM_CH-1:0] climit_in,
  output logic [pleb_pkg::NUM_CH-1:0] fault_out,
  output logic [pleb_pkg::NUM_CH-1:0] climit_out
);

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  logic [2:0] ch_idx;
  logic [3:0] reg_ofs;
  logic in_range;
  logic wr_en;
  logic [31:0] rdata_d;
  logic [31:0] rdata_q;

  assign ch_idx = paddr[6:4];
  assign reg_ofs = paddr[3:0];
  assign in_range = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00);
  assign wr_en = psel & penable & pwrite & in_range;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~in_range;

  // ----------------------------------------------------------------------
  // Pin synchronisers (three flops, second and third must agree)
  // ----------------------------------------------------------------------
  logic [pleb_pkg::NUM_CH-1:0] low_s1_q, low_s2_q, low_s3_q, low_q, low_d;
  logic [pleb_pkg::NUM_SRC-1:0] src_s1_q, src_s2_q, src_s3_q, src_q, src_d;

  always_comb begin
    low_d = low_q;
    src_d = src_q;
    for (int i = 0; i < int'(pleb_pkg::NUM_CH); i++) begin
      if (low_s2_q[i] == low_s3_q[i]) begin
        low_d[i] = low_s3_q[i];
      end
    end
    for (int i = 0; i < int'(pleb_pkg::NUM_SRC); i++) begin
      if (src_s2_q[i] == src_s3_q[i]) begin
        src_d[i] = src_s3_q[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_s1_q <= '0;
      low_s2_q <= '0;
      low_s3_q <= '0;
      low_q <= '0;
      src_s1_q <= '0;
      src_s2_q <= '0;
      src_s3_q <= '0;
      src_q <= '0;
    end else begin
      low_s1_q <= pwm_low_side_output;
      low_s2_q <= low_s1_q;
      low_s3_q <= low_s2_q;
      low_q <= low_d;
      src_s1_q <= blank_sources;
      src_s2_q <= src_s1_q;
      src_s3_q <= src_s2_q;
      src_q <= src_d;
    end
  end

  // ----------------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------------
  pleb_pkg::pleb_cfg_s [pleb_pkg::NUM_CH-1:0] cfg_q, cfg_d;
  logic [pleb_pkg::NUM_CH-1:0] blanking;
  logic [pleb_pkg::DLY_W-1:0] count [pleb_pkg::NUM_CH];

  // R6 eight channel copies
  for (genvar g = 0; g < pleb_pkg::NUM_CH; g++) begin : g_ch
    always_comb begin
      cfg_d[g] = cfg_q[g];
      if (wr_en && ch_idx == 3'(g)) begin
        unique case (reg_ofs)
          pleb_pkg::OFS_CONTROL: begin
            cfg_d[g].blank_when_low_side_high = pwdata[pleb_pkg::CTL_HIGH_BIT];
            cfg_d[g].blank_when_low_side_low = pwdata[pleb_pkg::CTL_LOW_BIT];
          end
          pleb_pkg::OFS_DELAY: begin
            // R3 delay field placement
            cfg_d[g].blanking_delay_count = pwdata[pleb_pkg::DLY_MSB:pleb_pkg::DLY_LSB];
          end
          pleb_pkg::OFS_AUX: begin
            // R4 source select field
            cfg_d[g].blanking_source_select = pwdata[pleb_pkg::AUX_SEL_MSB:pleb_pkg::AUX_SEL_LSB];
          end
          default: begin
          end
        endcase
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        // R5 delay resets zero
        cfg_q[g].blanking_delay_count <= pleb_pkg::DELAY_RESET;
        cfg_q[g].blank_when_low_side_high <= pleb_pkg::CONTROL_RESET[1];
        cfg_q[g].blank_when_low_side_low <= pleb_pkg::CONTROL_RESET[0];
        cfg_q[g].blanking_source_select <= pleb_pkg::AUX_RESET;
      end else begin
        cfg_q[g] <= cfg_d[g];
      end
    end

    pleb_channel u_ch (
      .pclk(pclk),
      .presetn(presetn),
      .cfg(cfg_q[g]),
      .pwm_low_side_output(low_q[g]),
      // R4 source mux
      .blank_source(src_q[cfg_q[g].blanking_source_select]),
      .fault_in(fault_in[g]),
      .climit_in(climit_in[g]),
      .fault_out(fault_out[g]),
      .climit_out(climit_out[g]),
      .blanking(blanking[g]),
      .count(count[g])
    );
  end

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (psel && !penable && !pwrite && in_range) begin
      unique case (reg_ofs)
        pleb_pkg::OFS_CONTROL: begin
          rdata_d[pleb_pkg::CTL_HIGH_BIT] = cfg_q[ch_idx].blank_when_low_side_high;
          rdata_d[pleb_pkg::CTL_LOW_BIT] = cfg_q[ch_idx].blank_when_low_side_low;
        end
        pleb_pkg::OFS_DELAY: begin
          // R5 unused bits read zero
          rdata_d[pleb_pkg::DLY_MSB:pleb_pkg::DLY_LSB] = cfg_q[ch_idx].blanking_delay_count;
        end
        pleb_pkg::OFS_AUX: begin
          rdata_d[pleb_pkg::AUX_SEL_MSB:pleb_pkg::AUX_SEL_LSB] =
            cfg_q[ch_idx].blanking_source_select;
        end
        pleb_pkg::OFS_STATUS: begin
          rdata_d[pleb_pkg::STAT_BLANK_BIT] = blanking[ch_idx];
          rdata_d[pleb_pkg::STAT_CNT_LSB +: pleb_pkg::DLY_W] = count[ch_idx];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      rdata_q <= rdata_d;
    end
  end

  assign prdata = rdata_q;

  // R3 write lands in field
  AST_DELAY_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && reg_ofs == pleb_pkg::OFS_DELAY && ch_idx == 3'h0)
    |=> cfg_q[0].blanking_delay_count == $past(pwdata[11:3]))
    else $error("delay write not stored in bits 11..3"); // R3
  // R5 reserved bits zero
  AST_DELAY_RSVD: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable && reg_ofs == pleb_pkg::OFS_DELAY) |=>
      prdata[2:0] == 3'h0 && prdata[31:12] == 20'h00000)
    else $error("reserved delay bits read nonzero"); // R5

  // ----------------------------------------------------------------------
  // Register file and path checks
  // ----------------------------------------------------------------------
  // R1 high enable stored
  AST_CTL_HIGH_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (wr_en && reg_ofs == pleb_pkg::OFS_CONTROL && ch_idx == 3'h0)
    |=> cfg_q[0].blank_when_low_side_high == $past(pwdata[pleb_pkg::CTL_HIGH_BIT]))
    else $error("control high enable not stored");

  // R2 low enable stored
  AST_CTL_LOW_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (wr_en && reg_ofs == pleb_pkg::OFS_CONTROL && ch_idx == 3'h0)
    |=> cfg_q[0].blank_when_low_side_low == $past(pwdata[pleb_pkg::CTL_LOW_BIT]))
    else $error("control low enable not stored");

  // R4 source select stored
  AST_AUX_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (wr_en && reg_ofs == pleb_pkg::OFS_AUX && ch_idx == 3'h0)
    |=> cfg_q[0].blanking_source_select == $past(pwdata[3:0]))
    else $error("source select not stored");

  // R6 last channel delay
  AST_DELAY_WRITE_LAST: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (wr_en && reg_ofs == pleb_pkg::OFS_DELAY && ch_idx == 3'h7)
    |=> cfg_q[7].blanking_delay_count == $past(pwdata[11:3]))
    else $error("last channel delay not stored");

  // R6 other channel untouched
  AST_CH_ISOLATION: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (wr_en && ch_idx != 3'h0)
    |=> $stable(cfg_q[0]))
    else $error("write to one channel changed another");

  // R6 no write no change
  AST_NO_WRITE_STABLE: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (!wr_en)
    |=> $stable(cfg_q))
    else $error("configuration changed without a write");

  // R6 refused write ignored
  AST_BAD_WRITE_IGNORED: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (psel && penable && pwrite && !in_range)
    |=> $stable(cfg_q))
    else $error("refused write changed configuration");

  // R6 refused access errors
  AST_BAD_ADDR_ERR: assert property (@(posedge pclk) disable iff (!presetn) // R6
    (psel && penable && paddr[7])
    |-> pslverr)
    else $error("unmapped access without error");

  // R5 refused read zero
  AST_BAD_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (psel && !penable && !in_range)
    |=> prdata == 32'h0000_0000)
    else $error("refused read returned data");

  // R1 control read back
  AST_CTL_READ: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (psel && !penable && !pwrite && in_range && reg_ofs == pleb_pkg::OFS_CONTROL)
    |=> prdata == {30'h0, $past(cfg_q[ch_idx].blank_when_low_side_high),
      $past(cfg_q[ch_idx].blank_when_low_side_low)})
    else $error("control read mismatch");

  // R3 delay read back
  AST_DELAY_READ: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (psel && !penable && !pwrite && in_range && reg_ofs == pleb_pkg::OFS_DELAY)
    |=> prdata[11:3] == $past(cfg_q[ch_idx].blanking_delay_count))
    else $error("delay read mismatch");

  // R4 select read back
  AST_AUX_READ: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (psel && !penable && !pwrite && in_range && reg_ofs == pleb_pkg::OFS_AUX)
    |=> prdata == {28'h0, $past(cfg_q[ch_idx].blanking_source_select)})
    else $error("source select read mismatch");

  // R7 status blanking bit
  AST_STATUS_READ: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (psel && !penable && !pwrite && in_range && reg_ofs == pleb_pkg::OFS_STATUS)
    |=> prdata[0] == $past(blanking[ch_idx]))
    else $error("status blanking bit mismatch");

  // R7 status count field
  AST_STATUS_COUNT: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (psel && !penable && !pwrite && in_range && reg_ofs == pleb_pkg::OFS_STATUS)
    |=> prdata[12:4] == $past(count[ch_idx]))
    else $error("status count mismatch");

  // R1 settled level taken
  AST_LOW_SYNC: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (low_s2_q[0] == low_s3_q[0])
    |=> low_q[0] == $past(low_s3_q[0]))
    else $error("settled low-side level not taken");

  // R1 unsettled level held
  AST_LOW_HOLD: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (low_s2_q[0] != low_s3_q[0])
    |=> low_q[0] == $past(low_q[0]))
    else $error("unsettled low-side level taken");

  // R4 settled source taken
  AST_SRC_SYNC: assert property (@(posedge pclk) disable iff (!presetn) // R4
    (src_s2_q == src_s3_q)
    |=> src_q == $past(src_s3_q))
    else $error("settled source level not taken");

  // R1 status shows state blanking
  AST_STATE_STATUS: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (cfg_q[0].blank_when_low_side_high && low_q[0])
    |-> blanking[0])
    else $error("state blanking not reported");

  // R7 idle input stays low
  AST_GATE_LOW: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (!fault_in[0])
    |=> !fault_out[0])
    else $error("fault output high with input low");

endmodule : pleb_top

// ---- verification/pleb_pwm_model.sv ----
// Model of the PWM generator and fault logic that feed the blanking block.
`timescale 1ns/1ps
module pleb_pwm_model #(
  parameter int unsigned PULSE = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Commands from the bench
  input wire logic [7:0] low_cmd,
  input wire logic [15:0] fire,
  input wire logic [7:0] fault_cmd,
  input wire logic [7:0] climit_cmd,
  // Levels towards the block
  output logic [7:0] pwm_low_side_output,
  output logic [15:0] blank_sources,
  output logic [7:0] fault_in,
  output logic [7:0] climit_in
);
  // A fire command becomes a source pulse long enough to pass the synchroniser.
  logic [3:0] left_q [16];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_low_side_output <= 8'h00;
      blank_sources <= 16'h0000;
      fault_in <= 8'h00;
      climit_in <= 8'h00;
      for (int i = 0; i < 16; i++) begin
        left_q[i] <= 4'h0;
      end
    end else begin
      pwm_low_side_output <= low_cmd;
      fault_in <= fault_cmd;
      climit_in <= climit_cmd;
      for (int i = 0; i < 16; i++) begin
        if (fire[i]) begin
          left_q[i] <= 4'(PULSE);
        end else if (left_q[i] != 4'h0) begin
          left_q[i] <= left_q[i] - 4'h1;
        end
        blank_sources[i] <= fire[i] || (left_q[i] > 4'h1);
      end
    end
  end
endmodule : pleb_pwm_model

// ---- verification/pleb_top_bench.sv ----
// Self-checking bench for the eight-channel leading-edge blanking block.
`timescale 1ns/1ps
`define CHK(act, exp) begin \
  tests_run++; \
  if ((act) !== (exp)) begin \
    miscompares++; \
    $display("[ERR] %0t got %h expected %h", $time, act, exp); \
  end \
end
module pleb_top_bench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, low_cmd, fault_cmd, climit_cmd, pwm_low, flt, cl, fault_out, climit_out;
  logic [31:0] pwdata, prdata, rd, w;
  logic [15:0] fire, srcs;
  logic [8:0] dly [8];
  logic [8:0] d;
  int miscompares, tests_run, ch, s, n;

  pleb_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_low_side_output(pwm_low), .blank_sources(srcs),
    .fault_in(flt), .climit_in(cl), .fault_out(fault_out), .climit_out(climit_out));

  pleb_pwm_model u_model (.pclk(pclk), .presetn(presetn), .low_cmd(low_cmd), .fire(fire),
    .fault_cmd(fault_cmd), .climit_cmd(climit_cmd), .pwm_low_side_output(pwm_low),
    .blank_sources(srcs), .fault_in(flt), .climit_in(cl));

  // ----------------------------------------------------------------------
  // Bus and helper tasks
  // ----------------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t bus transfer timed out", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [7:0] ra(int c, logic [3:0] ofs);
    return 8'(c * 16) + {4'h0, ofs};
  endfunction : ra

  // Expected blanked cycles: steps of 8.32 ns against a 40 ns clock.
  function automatic logic in_win(logic [8:0] dv, int cnt);
    int mid;
    mid = (int'(dv) * 208) / 1000;
    if (dv == 9'h000) begin
      return cnt == 0;
    end
    return (cnt >= mid - 1) && (cnt <= mid + 2);
  endfunction : in_win

  // Fires one source and counts cycles in which the channel's inputs are gated.
  task automatic measure(input int c, input int src, output int cnt);
    @(posedge pclk);
    fire <= 16'h0001 << src;
    @(posedge pclk);
    fire <= 16'h0000;
    cnt = 0;
    repeat (200) begin
      @(posedge pclk);
      if (fault_out[c] === 1'b0 && climit_out[c] === 1'b0) begin
        cnt++;
      end
    end
  endtask : measure

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // ----------------------------------------------------------------------
  // Clock and watchdog
  // ----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    #(40 * 20000);
    miscompares++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    low_cmd = 8'h00;
    fire = 16'h0000;
    fault_cmd = 8'hff;
    climit_cmd = 8'hff;
    void'($urandom(32'hd97fec71));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      for (int o = 0; o < 16; o += 4) begin
        apb(1'b0, ra(c, 4'(o)), 32'h0);
        `CHK(rd, 32'h0)
        `CHK(err, 1'b0)
      end
    end
    for (int c = 0; c < 8; c++) begin
      w = (c == 0) ? 32'hffffffff : $urandom;
      dly[c] = w[11:3];
      apb(1'b1, ra(c, pleb_pkg::OFS_DELAY), w);
      apb(1'b1, ra(c, pleb_pkg::OFS_CONTROL), 32'h0);
    end
    for (int c = 0; c < 8; c++) begin
      apb(1'b0, ra(c, pleb_pkg::OFS_DELAY), 32'h0);
      `CHK(rd, {20'h0, dly[c], 3'h0})
      w = $urandom;
      apb(1'b1, ra(c, pleb_pkg::OFS_AUX), w);
      apb(1'b0, ra(c, pleb_pkg::OFS_AUX), 32'h0);
      `CHK(rd, {28'h0, w[3:0]})
    end
    apb(1'b0, 8'h80, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b0, 8'h05, 32'h0);
    `CHK(err, 1'b1)
    ch = $urandom_range(7);
    for (int m = 0; m < 4; m++) begin
      for (int l = 0; l < 2; l++) begin
        apb(1'b1, ra(ch, pleb_pkg::OFS_CONTROL), 32'(m));
        low_cmd <= 8'(l) << ch;
        fault_cmd <= 8'($urandom);
        repeat (10) @(posedge pclk);
        `CHK(fault_out[ch], fault_cmd[ch] & !((l == 1 && m[1]) || (l == 0 && m[0])))
        `CHK(climit_out[ch], !((l == 1 && m[1]) || (l == 0 && m[0])))
        `CHK(fault_out | (8'h01 << ch), fault_cmd | (8'h01 << ch))
      end
    end
    apb(1'b1, ra(ch, pleb_pkg::OFS_CONTROL), 32'h0);
    low_cmd <= 8'h00;
    fault_cmd <= 8'hff;
    // timed blanking from the selected source
    for (int t = 0; t < 4; t++) begin
      ch = $urandom_range(7);
      s = $urandom_range(15);
      d = (t == 0) ? 9'h000 : (t == 1) ? 9'h1ff : 9'($urandom_range(511, 160));
      apb(1'b1, ra(ch, pleb_pkg::OFS_DELAY), {20'h0, d, 3'h0});
      apb(1'b1, ra(ch, pleb_pkg::OFS_AUX), 32'(s));
      measure(ch, s ^ 1, n);
      `CHK(n, 0)
      measure(ch, s, n);
      `CHK(in_win(d, n), 1'b1)
    end
    wrap_up();
  end
endmodule : pleb_top_bench
